//--- rtl/tsal_alarm_pins.sv
// tsal_alarm_pins: overtemperature, alert, address strap, reset, standby and bus timeout
// assumes temperatures and limits arrive on core_clk_in; pins are asynchronous
//
// How it works
// R1 - overtemp_out_1 is driven low only while temperature is above threshold 1.
// R2 - overtemp_out_2 is driven low only while temperature is above threshold 2.
// R3 - the alert pin is pulled low on a high-limit, low-limit or open-sensor event.
// R4 - the alert stays low until a status read or a won alert response transaction.
// R5 - the two address selects are caught once after power-up and set the slave address.
// R6 - while the hardware reset pin is high the overtemp, alert and serial registers return to their defaults; the strapped address and standby are kept.
// R7 - with standby low the block enters standby and freezes the overtemp and alert registers; the serial logic keeps running.
// R8 - data held low for 20 to 40 ms resets the serial interface.
// R9 - after that timeout the data line is released and the serial engine goes idle.
`timescale 1ns/1ps
module tsal_alarm_pins #(
  parameter int unsigned TIMEOUT_CYC = tsal_pkg::TIMEOUT_CYCLES
)
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  temp_in,
  input  wire logic [7:0]  ot1_limit_in,
  input  wire logic [7:0]  ot2_limit_in,
  input  wire logic [7:0]  high_limit_in,
  input  wire logic [7:0]  low_limit_in,
  input  wire logic        sensor_open_in,
  input  wire logic        status_read_in,
  input  wire logic        ara_won_in,
  input  wire logic        hw_reset_in,
  input  wire logic        standby_in,
  input  wire logic        addr_sel_0,
  input  wire logic        addr_sel_1,
  input  wire logic        smbdata_in,
  input  wire logic        serial_drive_low_in,
  output logic             overtemp_out_1,
  output logic             overtemp_out_1_oe_out,
  output logic             overtemp_out_2,
  output logic             overtemp_out_2_oe_out,
  output logic             alert_out,
  output logic             alert_oe_out,
  output logic             smbdata_out,
  output logic             smbdata_oe_out,
  output logic [6:0]       slave_addr_out,
  output logic             serial_idle_out,
  output logic             standby_out,
  output logic             regs_default_out
);

  initial
  begin
    // short limits are served as well, so a bench can shrink the 30 ms default
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > tsal_pkg::TIMEOUT_MAX_CYC)
      $error("tsal_alarm_pins: TIMEOUT_CYC must lie between 2 and the 40 ms ceiling");
  end

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] standby_in_sync;
    logic [1:0] data_sync;
    logic [1:0] sel0_sync;
    logic [1:0] sel1_sync;
    logic       strap_done;
    logic [6:0] slave_addr;
    logic       ot1_low;
    logic       ot2_low;
    logic       alert_low;
    logic       standby;
    logic       at_default;
    logic       strap_armed;
    logic       data_oe;
    logic       serial_idle;
  } tsal_top_s;

  tsal_top_s st_reg;
  tsal_top_s st_next;

  tsal_wd_if wd_if ();

  tsal_bus_watchdog #(
    .LIMIT_CYC (TIMEOUT_CYC)
  ) u_wd (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .wd          (wd_if.wd)
  );

  logic rst_act;
  logic alert_event;

  assign rst_act          = st_reg.rst_sync[1];
  assign wd_if.data_low   = !st_reg.data_sync[1];
  assign wd_if.clear      = rst_act;
  assign alert_event      = (temp_in > high_limit_in) || (temp_in < low_limit_in)
                            || sensor_open_in;

  // ==========================================================================
  // next-state logic
  always_comb
  begin
    st_next           = st_reg;
    st_next.rst_sync  = {st_reg.rst_sync[0], hw_reset_in};
    st_next.standby_in_sync = {st_reg.standby_in_sync[0], standby_in};
    st_next.data_sync = {st_reg.data_sync[0], smbdata_in};
    st_next.sel0_sync = {st_reg.sel0_sync[0], addr_sel_0};
    st_next.sel1_sync = {st_reg.sel1_sync[0], addr_sel_1};

    // strap is caught once, only after both synchroniser stages hold pin levels
    st_next.strap_armed = st_reg.strap_armed || !st_reg.at_default;
    if (!st_reg.strap_done && st_reg.strap_armed)
    begin
      st_next.strap_done = 1'b1;
      st_next.slave_addr = tsal_pkg::ADDR_BASE
                           | {5'h00, st_reg.sel1_sync[1], st_reg.sel0_sync[1]}; // R5
    end

    st_next.standby    = !st_reg.standby_in_sync[1]; // R7
    st_next.at_default = 1'b0;

    st_next.ot1_low = temp_in > ot1_limit_in; // R1
    st_next.ot2_low = temp_in > ot2_limit_in; // R2

    // set wins over acknowledge
    if (alert_event)
      st_next.alert_low = 1'b1; // R3
    else if (status_read_in || ara_won_in)
      st_next.alert_low = 1'b0; // R4

    if (wd_if.expired)
    begin
      st_next.data_oe     = 1'b0; // R9
      st_next.serial_idle = 1'b1; // R9
    end
    else
    begin
      st_next.data_oe     = serial_drive_low_in;
      st_next.serial_idle = st_reg.serial_idle && !serial_drive_low_in;
    end

    // standby freezes alarm state; registers are kept, not cleared
    if (st_reg.standby)
    begin
      st_next.ot1_low   = st_reg.ot1_low; // R7
      st_next.ot2_low   = st_reg.ot2_low;
      st_next.alert_low = st_reg.alert_low;
    end

    if (rst_act)
    begin
      st_next.ot1_low     = 1'b0; // R6
      st_next.ot2_low     = 1'b0;
      st_next.alert_low   = 1'b0;
      st_next.data_oe     = 1'b0;
      st_next.serial_idle = 1'b1;
      st_next.at_default  = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_reg             <= '0;
      st_reg.rst_sync    <= 2'h0;
      st_reg.standby_in_sync   <= 2'h3;
      st_reg.data_sync   <= 2'h3;
      st_reg.slave_addr  <= tsal_pkg::ADDR_BASE;
      st_reg.serial_idle <= 1'b1;
      st_reg.at_default  <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ==========================================================================
  // outputs
  assign overtemp_out_1        = 1'b0;
  assign overtemp_out_1_oe_out = st_reg.ot1_low;
  assign overtemp_out_2        = 1'b0;
  assign overtemp_out_2_oe_out = st_reg.ot2_low;
  assign alert_out             = 1'b0;
  assign alert_oe_out          = st_reg.alert_low;
  assign smbdata_out           = 1'b0;
  assign smbdata_oe_out        = st_reg.data_oe;
  assign slave_addr_out        = st_reg.slave_addr;
  assign serial_idle_out       = st_reg.serial_idle;
  assign standby_out           = st_reg.standby;
  assign regs_default_out      = st_reg.at_default;

endmodule // tsal_alarm_pins

//--- common/tsal_pkg.sv
// tsal_pkg: constants shared by the alarm pin logic and its bus watchdog
// assumes a 100 MHz core clock
package tsal_pkg;

  localparam int unsigned CLK_FREQ_HZ       = 100_000_000;
  localparam int unsigned TIMEOUT_MIN_MS    = 20;
  localparam int unsigned TIMEOUT_MAX_MS    = 40;
  // aim at the middle of the window so pin synchroniser delay cannot push past either end
  localparam int unsigned TIMEOUT_NOM_MS    = (TIMEOUT_MIN_MS + TIMEOUT_MAX_MS) / 2;
  localparam int unsigned TIMEOUT_CYCLES    = (CLK_FREQ_HZ / 1000) * TIMEOUT_NOM_MS;
  localparam int unsigned TIMEOUT_MIN_CYC   = (CLK_FREQ_HZ / 1000) * TIMEOUT_MIN_MS;
  localparam int unsigned TIMEOUT_MAX_CYC   = (CLK_FREQ_HZ / 1000) * TIMEOUT_MAX_MS;

  localparam int unsigned ADDR_W            = 7;
  localparam int unsigned TEMP_W            = 8;
  localparam int unsigned SEL_W             = 2;

  // base slave address; the two select bits fill the low bits (value arbitrary)
  localparam logic [6:0]  ADDR_BASE         = 7'h4C;
  localparam logic [1:0]  SEL_RESET         = 2'h0;

endpackage

//--- common/tsal_wd_if.sv
// tsal_wd_if: carries timeout request and report between top and watchdog
// assumes both ends share core_clk_in
`timescale 1ns/1ps
interface tsal_wd_if;
  logic data_low;
  logic clear;
  logic expired;

  modport top
  (
    output data_low,
    output clear,
    input  expired
  );

  modport wd
  (
    input  data_low,
    input  clear,
    output expired
  );
endinterface

//--- rtl/tsal_bus_watchdog.sv
// tsal_bus_watchdog: counts cycles of data held low, pulses expired at the limit
// assumes data_low is already synchronised to core_clk_in
`timescale 1ns/1ps
module tsal_bus_watchdog #(
  parameter int unsigned LIMIT_CYC = tsal_pkg::TIMEOUT_CYCLES
)
(
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  tsal_wd_if.wd     wd
);

  localparam int unsigned CNT_W = $clog2(LIMIT_CYC + 1);

  initial
  begin
    if (LIMIT_CYC < 2)
      $error("tsal_bus_watchdog: LIMIT_CYC must be at least 2");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             expired;
  } tsal_wd_s;

  tsal_wd_s st_reg;
  tsal_wd_s st_next;

  assign wd.expired = st_reg.expired;

  // ==========================================================================
  // low-time counter
  always_comb
  begin
    st_next         = st_reg;
    st_next.expired = 1'b0;
    if (!wd.data_low || wd.clear)
      st_next.cnt = '0;
    else if (st_reg.cnt == CNT_W'(LIMIT_CYC - 1))
    begin
      st_next.expired = 1'b1; // R8
      st_next.cnt     = '0;
    end
    else
      st_next.cnt = st_reg.cnt + CNT_W'(1);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

endmodule // tsal_bus_watchdog

//--- dv/tsal_host_model.sv
// host side of the pins: pulled-up open-drain data and alert lines
// assumes an oe high means the device sinks its line
`timescale 1ns/1ps
module tsal_host_model
(
  input  wire logic host_low_in,
  input  wire logic dat_oe_in,
  input  wire logic al_oe_in,
  output logic      dat_out,
  output logic      al_out
);
  // a released line reads as the pull-up level
  assign dat_out = !(host_low_in || dat_oe_in);
  assign al_out  = !al_oe_in;
endmodule // tsal_host_model

//--- dv/tsal_alarm_pins_assertions.sv
// checker for the alarm pin logic, bound to the top module
// assumes one-cycle alarm latency and synchronised pins
`timescale 1ns/1ps
module tsal_alarm_pins_assertions #(
  parameter int unsigned TIMEOUT_CYC = 100
)
(
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] temp_in,
  input wire logic [7:0] ot1_limit_in,
  input wire logic [7:0] ot2_limit_in,
  input wire logic [7:0] high_limit_in,
  input wire logic [7:0] low_limit_in,
  input wire logic       sensor_open_in,
  input wire logic       status_read_in,
  input wire logic       ara_won_in,
  input wire logic       hw_reset_in,
  input wire logic       standby_in,
  input wire logic       smbdata_in,
  input wire logic       overtemp_out_1_oe_out,
  input wire logic       overtemp_out_2_oe_out,
  input wire logic       alert_oe_out,
  input wire logic       smbdata_oe_out,
  input wire logic [6:0] slave_addr_out,
  input wire logic       serial_idle_out,
  input wire logic       standby_out,
  input wire logic       regs_default_out
);
  logic       ev;
  logic [2:0] up_reg;
  int         low_reg;
  assign ev = temp_in > high_limit_in || temp_in < low_limit_in || sensor_open_in;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      up_reg  <= 3'h0;
      low_reg <= 0;
    end
    else
    begin
      up_reg  <= up_reg + 3'(up_reg != 3'h4);
      low_reg <= smbdata_in ? 0 : low_reg + 1;
    end
  end
  // ==========
  // properties
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence calm;
    (!hw_reset_in && standby_in) [*4];
  endsequence
  a_ot1_hot: assert property (calm ##0 temp_in > ot1_limit_in |=> overtemp_out_1_oe_out)
    else $error("ot1 not sunk while hot");
  a_ot1_cool: assert property (calm ##0 temp_in <= ot1_limit_in |=> !overtemp_out_1_oe_out)
    else $error("ot1 sunk while cool");
  a_ot2_hot: assert property (calm ##0 temp_in > ot2_limit_in |=> overtemp_out_2_oe_out)
    else $error("ot2 not sunk while hot");
  a_ot2_cool: assert property (calm ##0 temp_in <= ot2_limit_in |=> !overtemp_out_2_oe_out)
    else $error("ot2 sunk while cool");
  a_alert_set: assert property (calm ##0 ev |=> alert_oe_out)
    else $error("alert missed an event");
  a_alert_hold: assert property (calm ##0 alert_oe_out && !status_read_in
    && !ara_won_in |=> alert_oe_out) else $error("alert dropped unacked");
  a_alert_ack: assert property (calm ##0 alert_oe_out && !ev
    && (status_read_in || ara_won_in) |=> !alert_oe_out) else $error("alert kept after ack");
  a_addr_hold: assert property (up_reg == 3'h4 |-> $stable(slave_addr_out))
    else $error("address moved after capture");
  a_standby_in_enter: assert property (!standby_in [*5] |-> standby_out)
    else $error("standby not entered");
  a_hwr_clear: assert property (hw_reset_in [*5] |-> regs_default_out && serial_idle_out
    && !alert_oe_out && !overtemp_out_1_oe_out) else $error("hw reset not applied");
  a_to_release: assert property (low_reg == TIMEOUT_CYC + 3
    |-> ##[0:2] !smbdata_oe_out && serial_idle_out) else $error("no timeout release");
endmodule // tsal_alarm_pins_assertions
bind tsal_alarm_pins tsal_alarm_pins_assertions #(
  .TIMEOUT_CYC (TIMEOUT_CYC)
) chk_u (
  .core_clk_in           (core_clk_in),
  .rst_n_in              (rst_n_in),
  .temp_in               (temp_in),
  .ot1_limit_in          (ot1_limit_in),
  .ot2_limit_in          (ot2_limit_in),
  .high_limit_in         (high_limit_in),
  .low_limit_in          (low_limit_in),
  .sensor_open_in        (sensor_open_in),
  .status_read_in        (status_read_in),
  .ara_won_in            (ara_won_in),
  .hw_reset_in           (hw_reset_in),
  .standby_in            (standby_in),
  .smbdata_in            (smbdata_in),
  .overtemp_out_1_oe_out (overtemp_out_1_oe_out),
  .overtemp_out_2_oe_out (overtemp_out_2_oe_out),
  .alert_oe_out          (alert_oe_out),
  .smbdata_oe_out        (smbdata_oe_out),
  .slave_addr_out        (slave_addr_out),
  .serial_idle_out       (serial_idle_out),
  .standby_out           (standby_out),
  .regs_default_out      (regs_default_out)
);

//--- dv/tsal_alarm_pins_bench.sv
// bench for the alarm pin logic with a pulled-up host side
// assumes the timeout shortened to 100 cycles
`timescale 1ns/1ps
module tsal_alarm_pins_bench;
  localparam int unsigned TCYC = 100;
  logic       clk = 1'b0, rst_n = 1'b0, s0 = 1'b0, s1 = 1'b1;
  logic [7:0] t = 8'h20, l1 = 8'h50, l2 = 8'h60, hi = 8'h40, lo = 8'h10;
  logic       so = 1'b0, sr = 1'b0, aw = 1'b0, hr = 1'b0, st = 1'b1, drv = 1'b0;
  logic       o1, o2, ao, al, doe, dat, idle, sb, rd;
  logic       od1, od2, oal, odat;
  logic [6:0] sa;
  int         n_errors = 0, checks_done = 0, cyc = 0, n;
  always #5 clk = ~clk;
  tsal_host_model host_u (.host_low_in(1'b0), .dat_oe_in(doe), .al_oe_in(ao), .dat_out(dat),
    .al_out(al));
  tsal_alarm_pins #(.TIMEOUT_CYC(TCYC)) dut_u (.core_clk_in(clk), .rst_n_in(rst_n),
    .temp_in(t), .ot1_limit_in(l1), .ot2_limit_in(l2), .high_limit_in(hi), .low_limit_in(lo),
    .sensor_open_in(so), .status_read_in(sr), .ara_won_in(aw), .hw_reset_in(hr),
    .standby_in(st), .addr_sel_0(s0), .addr_sel_1(s1), .smbdata_in(dat),
    .serial_drive_low_in(drv), .overtemp_out_1(od1), .overtemp_out_1_oe_out(o1),
    .overtemp_out_2(od2), .overtemp_out_2_oe_out(o2), .alert_out(oal), .alert_oe_out(ao),
    .smbdata_out(odat), .smbdata_oe_out(doe), .slave_addr_out(sa), .serial_idle_out(idle),
    .standby_out(sb), .regs_default_out(rd));
  // ==========
  // tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic ack(input logic won);
    sr = !won;
    aw = won;
    step(1);
    sr = 1'b0;
    aw = 1'b0;
    step(1);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_ot;
    t = l1;
    step(2);
    chk(o1, 1'b0);
    t = l1 + 8'h1;
    step(2);
    chk({o1, o2}, 2'h2);
    chk({od1, od2, oal, odat}, 4'h0);
    t = l2 + 8'h1;
    step(2);
    chk(o2, 1'b1);
    t = 8'h20;
    step(2);
    chk({o1, o2}, 2'h0);
    ack(1'b0);
  endtask
  task automatic t_alert;
    for (int k = 0; k < 3; k++)
    begin
      t = (k == 0) ? hi + 8'h1 : (k == 1) ? lo - 8'h1 : 8'h20;
      so = (k == 2);
      step(2);
      t = 8'h20;
      so = 1'b0;
      step(3);
      chk(al, 1'b0);
      ack(k == 1);
      chk(al, 1'b1);
    end
  endtask
  task automatic t_sby;
    st = 1'b0;
    step(5);
    chk(sb, 1'b1);
    t = l2 + 8'h1;
    step(3);
    chk({o1, o2, ao}, 3'h0);
    st = 1'b1;
    step(6);
    chk({o1, o2, sb}, 3'h6);
    t = 8'h20;
    step(2);
    ack(1'b0);
  endtask
  task automatic t_hwr;
    t = hi + 8'h1;
    step(2);
    hr = 1'b1;
    step(6);
    chk({ao, rd, idle, sa}, {3'h3, tsal_pkg::ADDR_BASE | 7'h2});
    t = 8'h20;
    hr = 1'b0;
    step(6);
    chk({ao, rd}, 2'h0);
  endtask
  task automatic t_to;
    drv = 1'b1;
    n = 0;
    step(1);
    while (doe === 1'b1 && n < 2 * TCYC)
    begin
      step(1);
      n++;
    end
    chk(idle, 1'b1);
    chk(n >= TCYC && n <= TCYC + 6, 1'b1);
    drv = 1'b0;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      close_out;
    end
  end
  initial
  begin
    step(16);
    rst_n = 1'b1;
    step(4);
    chk(sa, tsal_pkg::ADDR_BASE | 7'h2);
    t_ot;
    t_alert;
    t_sby;
    t_hwr;
    t_to;
    close_out;
  end
endmodule // tsal_alarm_pins_bench
